/* File: rtl/cmt_pkg.sv */
// Package for the compare match timer: register offsets, field layouts,
// clock-select encodings and the sub-clock timing counts.
// Assumes a 32-bit AXI4-Lite register bus with one byte per aligned word.
`default_nettype none

package cmt_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_CNT_HIGH = 8'h08;
    localparam logic [7:0] OFS_CNT_LOW  = 8'h0C;
    localparam logic [7:0] OFS_CMP_HIGH = 8'h10;
    localparam logic [7:0] OFS_CMP_LOW  = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h18;
    localparam logic [7:0] OFS_IRQ_REQ  = 8'h1C;

    // Reset values and the all-ones byte
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET    = 8'h00;
    localparam logic [7:0] CMP_RESET    = 8'hFF;
    localparam logic [7:0] BYTE_MAX     = 8'hFF;

    // Clock-select source codes (low two bits of each field)
    localparam logic [1:0] SRC_DIV32    = 2'h0;
    localparam logic [1:0] SRC_DIV16    = 2'h1;
    localparam logic [1:0] SRC_DIV4     = 2'h2;
    localparam logic [1:0] SRC_SUB_DIV4 = 2'h3;

    // Sub-clock timing in sub-clock cycles
    localparam logic [1:0] SUB_DIVIDE   = 2'h3;  // Divide by 4: terminal count
    localparam logic [1:0] EVENT_HOLD   = 2'h2;  // Overflow/match signal width
    localparam logic [1:0] IRQ_HOLD     = 2'h1;  // Interrupt source signal width

    // Bus responses
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_DECERR  = 2'h3;

    // Timer control register layout
    typedef struct packed {
        logic       high_output_level;
        logic [2:0] high_clock_sel;   // Top bit selects dual 8-bit mode
        logic       low_output_level;
        logic [2:0] low_clock_sel;
    } cmt_ctrl_type;

    // Timer status register layout
    typedef struct packed {
        logic high_overflow_flag;
        logic high_match_flag;
        logic high_overflow_irq_en;
        logic high_clear_on_match;
        logic low_overflow_flag;
        logic low_match_flag;
        logic low_overflow_irq_en;
        logic low_clear_on_match;
    } cmt_status_type;

    // Prescaler tick bundle, one-cycle pulses on CLK
    typedef struct packed {
        logic div32;
        logic div16;
        logic div4;
    } cmt_ticks_type;

endpackage : cmt_pkg

`default_nettype wire

/* File: rtl/cmt_top.sv */
// Compare match timer: one 16-bit or two 8-bit up-counters with compare,
// overflow, toggle outputs, interrupt request pulses and an AXI4-Lite slave.
// Assumes prescaler ticks on CLK and a raw asynchronous sub-clock pin.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`default_nettype none

module cmt_top (
    input  wire logic                   CLK,
    input  wire logic                   RST,
    input  wire cmt_pkg::cmt_ticks_type PRESCALE_TICK,
    input  wire logic                   SUB_CLOCK,
    input  wire logic                   SUB_ACTIVE,
    input  wire logic [7:0]             AWADDR,
    input  wire logic                   AWVALID,
    output logic                        AWREADY,
    input  wire logic [31:0]            WDATA,
    input  wire logic [3:0]             WSTRB,
    input  wire logic                   WVALID,
    output logic                        WREADY,
    output logic [1:0]                  BRESP,
    output logic                        BVALID,
    input  wire logic                   BREADY,
    input  wire logic [7:0]             ARADDR,
    input  wire logic                   ARVALID,
    output logic                        ARREADY,
    output logic [31:0]                 RDATA,
    output logic [1:0]                  RRESP,
    output logic                        RVALID,
    input  wire logic                   RREADY,
    output logic                        HIGH_TOGGLE_PIN,
    output logic                        LOW_TOGGLE_PIN,
    output logic                        HIGH_IRQ,
    output logic                        LOW_IRQ
);
    import cmt_pkg::*;

    cmt_ctrl_type   timer_control_reg;
    cmt_status_type timer_status_reg;
    logic [7:0]     aw_addr;
    logic [7:0]     w_data;
    logic           w_strb;
    logic           aw_full;
    logic           w_full;
    logic           next_aw_full;
    logic           next_w_full;
    logic           wr_do;
    logic           rd_do;
    logic [7:0]     rd_byte;
    logic           rd_hit;
    logic           wr_hit;
    logic           wr_byte;
    logic [7:0]     hold_byte;
    logic [7:0]     counter_high_byte;
    logic [7:0]     counter_low_byte;
    logic [7:0]     compare_high_byte;
    logic [7:0]     compare_low_byte;
    logic [1:0]     interrupt_enable_reg;
    logic [1:0]     irq_request_flag;
    logic [1:0]     match_flag;
    logic [1:0]     overflow_flag;
    logic [1:0]     seen_match;
    logic [1:0]     seen_overflow;
    logic [1:0]     seen_request;
    logic           sub_meta;
    logic           sub_sync;
    logic           sub_last;
    logic           sub_edge;
    logic [1:0]     sub_div;
    logic           sub_tick;
    logic           dual_mode;
    logic           tick_low;
    logic           tick_high;
    logic [1:0]     sel_src [2];
    logic [1:0]     cnt_wr;
    logic [1:0]     cmp_commit;
    logic [1:0]     match_ev;
    logic [1:0]     overflow_ev;
    logic [1:0]     irq_ev;
    logic [1:0]     clear_on_match;
    logic [1:0]     ovf_irq_en;
    logic [1:0]     out_level;
    logic [1:0]     write_blocked;
    logic [1:0]     pin;
    logic [1:0]     irq_pulse;
    logic [1:0]     ctrl_wr;
    logic           status_wr;
    logic           request_wr;

    assign dual_mode  = timer_control_reg.high_clock_sel[2];
    assign sel_src[0] = timer_control_reg.low_clock_sel[1:0];
    assign sel_src[1] = timer_control_reg.high_clock_sel[1:0];

    // Source picker; in sub-clock active mode only the sub-clock can count
    function automatic logic pick_tick(input logic [1:0] sel, input cmt_ticks_type pre,
                                       input logic sub, input logic sub_mode);
        logic t;
        t = 1'b0;
        unique case (sel)
            SRC_DIV32:    t = pre.div32;
            SRC_DIV16:    t = pre.div16;
            SRC_DIV4:     t = pre.div4;
            SRC_SUB_DIV4: t = sub;
        endcase
        return sub_mode ? (sel == SRC_SUB_DIV4) & t : t;
    endfunction : pick_tick

    // Sub-clock pin synchroniser; costs up to one CLK period of count error
    always_ff @(posedge CLK) begin
        if (RST) begin
            sub_meta <= 1'b0;
            sub_sync <= 1'b0;
            sub_last <= 1'b0;
        end else begin
            sub_meta <= SUB_CLOCK;
            sub_sync <= sub_meta;
            sub_last <= sub_sync;
        end
    end

    assign sub_edge = sub_sync & ~sub_last;

    always_ff @(posedge CLK) begin
        if (RST) begin
            sub_div <= 2'h0;
        end else if (sub_edge) begin
            sub_div <= sub_div + 2'h1;
        end
    end

    assign sub_tick = sub_edge & (sub_div == SUB_DIVIDE);

    // counter clocks; in 16-bit mode the low field drives both
    assign tick_low  = pick_tick(sel_src[0], PRESCALE_TICK, sub_tick, SUB_ACTIVE);
    assign tick_high = dual_mode ? pick_tick(sel_src[1], PRESCALE_TICK, sub_tick, SUB_ACTIVE)
                                 : tick_low;

    // AXI write channel bookkeeping; address and data accepted in any order
    always_comb begin
        next_aw_full = aw_full;
        next_w_full  = w_full;
        if (AWVALID && AWREADY) begin
            next_aw_full = 1'b1;
        end
        if (WVALID && WREADY) begin
            next_w_full = 1'b1;
        end
        if (wr_do) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
        end
    end

    assign wr_do = aw_full & w_full & ~BVALID;
    assign rd_do = ARVALID & ARREADY;

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 8'h00;
            w_strb  <= 1'b0;
        end else begin
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            AWREADY <= ~next_aw_full;
            WREADY  <= ~next_w_full;
            if (AWVALID && AWREADY) begin
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_data <= WDATA[7:0];
                w_strb <= WSTRB[0];
            end
        end
    end

    // Write response rises on the same edge as the register update
    always_ff @(posedge CLK) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP  <= RESP_OKAY;
        end else if (wr_do) begin
            BVALID <= 1'b1;
            BRESP  <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    assign wr_hit  = (aw_addr[7:5] == 3'h0) && (aw_addr[1:0] == 2'h0);
    assign wr_byte = wr_do & wr_hit & w_strb;

    assign ctrl_wr[0] = wr_byte & (aw_addr == OFS_CTRL);
    assign ctrl_wr[1] = ctrl_wr[0];
    assign status_wr  = wr_byte & (aw_addr == OFS_STATUS);
    assign request_wr = wr_byte & (aw_addr == OFS_IRQ_REQ);

    // full-speed counter writes are lost while the sub-clock drives the half
    assign write_blocked[0] = ~SUB_ACTIVE & (sel_src[0] == SRC_SUB_DIV4);
    assign write_blocked[1] = ~SUB_ACTIVE & (sel_src[dual_mode ? 1 : 0] == SRC_SUB_DIV4);

    // 16-bit mode commits both bytes on the low-byte write
    assign cnt_wr[0] = wr_byte & (aw_addr == OFS_CNT_LOW) & ~write_blocked[0];
    assign cnt_wr[1] = wr_byte & ~write_blocked[1]
                     & (dual_mode ? (aw_addr == OFS_CNT_HIGH) : (aw_addr == OFS_CNT_LOW));
    assign cmp_commit[0] = wr_byte & (aw_addr == OFS_CMP_LOW);
    assign cmp_commit[1] = wr_byte
                         & (dual_mode ? (aw_addr == OFS_CMP_HIGH) : (aw_addr == OFS_CMP_LOW));

    // Register read mux; all bytes sit in the low lane
    always_comb begin
        rd_hit  = (ARADDR[7:5] == 3'h0) && (ARADDR[1:0] == 2'h0);
        rd_byte = 8'h00;
        unique case (ARADDR)
            OFS_CTRL:     rd_byte = timer_control_reg;
            OFS_STATUS:   rd_byte = timer_status_reg;
            OFS_CNT_HIGH: rd_byte = counter_high_byte;
            OFS_CNT_LOW:  rd_byte = dual_mode ? counter_low_byte : hold_byte;
            OFS_CMP_HIGH: rd_byte = compare_high_byte;
            OFS_CMP_LOW:  rd_byte = compare_low_byte;
            OFS_IRQ_EN:   rd_byte = {6'h00, interrupt_enable_reg};
            OFS_IRQ_REQ:  rd_byte = {6'h00, irq_request_flag};
            default:      rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= RESP_OKAY;
        end else if (rd_do) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= {24'h00_0000, rd_byte};
            RRESP   <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (RVALID && RREADY) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
        end else if (!RVALID) begin
            ARREADY <= 1'b1;
        end
    end

    // holding byte: high write parks data, high counter read latches low
    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_byte <= 8'h00;
        end else if (rd_do && ARADDR == OFS_CNT_HIGH) begin
            hold_byte <= counter_low_byte;
        end else if (wr_byte && (aw_addr == OFS_CNT_HIGH || aw_addr == OFS_CMP_HIGH)) begin
            hold_byte <= w_data;
        end
    end

    // Control, enables and configuration bits
    always_ff @(posedge CLK) begin
        if (RST) begin
            timer_control_reg    <= CTRL_RESET;
            interrupt_enable_reg <= 2'h0;
            clear_on_match       <= 2'h0;
            ovf_irq_en           <= 2'h0;
        end else begin
            if (ctrl_wr[0]) begin
                timer_control_reg <= w_data;
            end
            if (wr_byte && aw_addr == OFS_IRQ_EN) begin
                interrupt_enable_reg <= w_data[1:0];
            end
            if (status_wr) begin
                clear_on_match <= {w_data[4], w_data[0]};
                ovf_irq_en     <= {w_data[5], w_data[1]};
            end
        end
    end

    assign out_level = {timer_control_reg.high_output_level, timer_control_reg.low_output_level};

    // compare bytes; the committed write kills that cycle's match
    always_ff @(posedge CLK) begin
        if (RST) begin
            compare_high_byte <= CMP_RESET;
            compare_low_byte  <= CMP_RESET;
        end else begin
            if (cmp_commit[1]) begin
                compare_high_byte <= dual_mode ? w_data : hold_byte;
            end
            if (cmp_commit[0]) begin
                compare_low_byte <= w_data;
            end
        end
    end

    // events only on a counter tick, leaving the matching value
    // low byte conditions also evaluated in 16-bit mode
    assign match_ev[0]    = tick_low & (counter_low_byte == compare_low_byte) & ~cmp_commit[0];
    // overflow dropped when the byte is written
    assign overflow_ev[0] = tick_low & (counter_low_byte == BYTE_MAX) & ~cnt_wr[0];
    // full 16-bit compare or high byte alone
    assign match_ev[1]    = tick_high & ~cmp_commit[1] & ~(~dual_mode & cmp_commit[0])
                          & (counter_high_byte == compare_high_byte)
                          & (dual_mode | (counter_low_byte == compare_low_byte));
    assign overflow_ev[1] = tick_high & ~cnt_wr[1] & ~(~dual_mode & cnt_wr[0])
                          & (counter_high_byte == BYTE_MAX)
                          & (dual_mode | (counter_low_byte == BYTE_MAX));

    // Counter halves; a write beats the increment
    always_ff @(posedge CLK) begin
        if (RST) begin
            counter_low_byte  <= CNT_RESET;
            counter_high_byte <= CNT_RESET;
        end else begin
            if (cnt_wr[0]) begin
                counter_low_byte <= w_data;
            // clear on match, 16-bit mode uses the high enable
            end else if (tick_low && (dual_mode ? match_ev[0] & clear_on_match[0]
                                                : match_ev[1] & clear_on_match[1])) begin
                counter_low_byte <= CNT_RESET;
            end else if (tick_low) begin
                counter_low_byte <= counter_low_byte + 8'h01;
            end
            if (cnt_wr[1]) begin
                counter_high_byte <= dual_mode ? w_data : hold_byte;
            end else if (tick_high && match_ev[1] && clear_on_match[1]) begin
                counter_high_byte <= CNT_RESET;
            // carry from the low byte in 16-bit mode
            end else if (tick_high && (dual_mode || counter_low_byte == BYTE_MAX)) begin
                counter_high_byte <= counter_high_byte + 8'h01;
            end
        end
    end

    assign irq_ev = interrupt_enable_reg & (match_ev | (overflow_ev & ovf_irq_en));

    // Per-half flags, pins and interrupt pulses; index 0 low, 1 high
    for (genvar i = 0; i < 2; i++) begin : g_half
        logic [1:0] hold_cnt;
        logic [1:0] irq_win;
        logic       stretch;

        // stretch only with sub-clock source at full speed
        assign stretch = ~SUB_ACTIVE & (sel_src[dual_mode ? i : 0] == SRC_SUB_DIV4);

        // validity windows counted in sub-clock cycles
        always_ff @(posedge CLK) begin
            if (RST) begin
                hold_cnt <= 2'h0;
                irq_win  <= 2'h0;
            end else begin
                if ((match_ev[i] || overflow_ev[i]) && stretch) begin
                    hold_cnt <= EVENT_HOLD;
                end else if (sub_edge && hold_cnt != 2'h0) begin
                    hold_cnt <= hold_cnt - 2'h1;
                end
                if (irq_ev[i] && stretch) begin
                    irq_win <= IRQ_HOLD;
                end else if (sub_edge && irq_win != 2'h0) begin
                    irq_win <= irq_win - 2'h1;
                end
            end
        end

        // status flags: set wins, clear needs read-as-one
        always_ff @(posedge CLK) begin
            if (RST) begin
                match_flag[i]    <= 1'b0;
                overflow_flag[i] <= 1'b0;
                seen_match[i]    <= 1'b0;
                seen_overflow[i] <= 1'b0;
            end else begin
                if (rd_do && ARADDR == OFS_STATUS) begin
                    seen_match[i]    <= match_flag[i];
                    seen_overflow[i] <= overflow_flag[i];
                end
                if (match_ev[i]) begin
                    match_flag[i] <= 1'b1;
                end else if (status_wr && !w_data[2 + 4 * i] && seen_match[i]
                             && hold_cnt == 2'h0) begin
                    match_flag[i] <= 1'b0;
                    seen_match[i] <= 1'b0;
                end
                if (overflow_ev[i]) begin
                    overflow_flag[i] <= 1'b1;
                end else if (status_wr && !w_data[3 + 4 * i] && seen_overflow[i]
                             && hold_cnt == 2'h0) begin
                    overflow_flag[i] <= 1'b0;
                    seen_overflow[i] <= 1'b0;
                end
            end
        end

        // request flag re-sets while its source pulse is valid
        always_ff @(posedge CLK) begin
            if (RST) begin
                irq_request_flag[i] <= 1'b0;
                seen_request[i]     <= 1'b0;
            end else begin
                if (rd_do && ARADDR == OFS_IRQ_REQ) begin
                    seen_request[i] <= irq_request_flag[i];
                end
                if (irq_ev[i] || irq_win != 2'h0) begin
                    irq_request_flag[i] <= 1'b1;
                end else if (request_wr && !w_data[i] && seen_request[i]) begin
                    irq_request_flag[i] <= 1'b0;
                    seen_request[i]     <= 1'b0;
                end
            end
        end

        // control write wins over a coincident toggle
        always_ff @(posedge CLK) begin
            if (RST) begin
                pin[i] <= 1'b0;
            end else if (ctrl_wr[i]) begin
                pin[i] <= w_data[3 + 4 * i];
            end else if (match_ev[i]) begin
                pin[i] <= ~pin[i];
            end
        end

        always_ff @(posedge CLK) begin
            if (RST) begin
                irq_pulse[i] <= 1'b0;
            end else begin
                irq_pulse[i] <= irq_ev[i];
            end
        end
    end

    // Status byte as software sees it
    always_comb begin
        timer_status_reg                      = STATUS_RESET;
        timer_status_reg.high_overflow_flag   = overflow_flag[1];
        timer_status_reg.high_match_flag      = match_flag[1];
        timer_status_reg.high_overflow_irq_en = ovf_irq_en[1];
        timer_status_reg.high_clear_on_match  = clear_on_match[1];
        timer_status_reg.low_overflow_flag    = overflow_flag[0];
        timer_status_reg.low_match_flag       = match_flag[0];
        timer_status_reg.low_overflow_irq_en  = ovf_irq_en[0];
        timer_status_reg.low_clear_on_match   = clear_on_match[0];
    end

    // Low pin still toggles in 16-bit mode; its level is not meaningful there
    assign HIGH_TOGGLE_PIN = pin[1];
    assign LOW_TOGGLE_PIN  = pin[0];
    assign HIGH_IRQ        = irq_pulse[1];
    assign LOW_IRQ         = irq_pulse[0];

endmodule : cmt_top

`default_nettype wire

/* File: verif/cmt_chk.sv */
// Bus handshake and interrupt pulse assertions for the timer.
// Assumes one clock domain, CLK rising, RST synchronous active high.
`default_nettype none
module cmt_chk
    import cmt_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        HIGH_IRQ,
    input wire logic        LOW_IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Answers stand until the master takes them
    a_b_hold: assert property (BVALID && !BREADY |=> BVALID) else $error("bresp dropped");
    a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("rdata moved");
    a_r_done: assert property (RVALID && RREADY |=> !RVALID) else $error("rvalid stuck");
    a_r_lat: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read answer late");
    // Byte-wide registers, refused reads give zero
    a_r_upper: assert property (RVALID |-> RDATA[31:8] == 24'h00_0000) else $error("upper bits");
    a_r_err: assert property (RVALID && RRESP == RESP_DECERR |-> RDATA == 32'h0000_0000)
        else $error("decerr data");
    a_hirq_pulse: assert property (HIGH_IRQ |=> !HIGH_IRQ) else $error("high irq wide");
    a_lirq_pulse: assert property (LOW_IRQ |=> !LOW_IRQ) else $error("low irq wide");
    c_hirq: cover property (HIGH_IRQ);
    c_lirq: cover property (LOW_IRQ);
    c_err: cover property (RVALID && RRESP == RESP_DECERR);
endmodule : cmt_chk
bind cmt_top cmt_chk u_chk (.*);
`default_nettype wire

/* File: verif/cmt_src_model.sv */
// Clock source model: prescaler ticks and a free-running sub-clock.
// Assumes clk is the system clock; ticks are one-cycle pulses.
`default_nettype none
module cmt_src_model (
    input  wire logic                clk,
    input  wire logic                rst,
    output var cmt_pkg::cmt_ticks_type tick,
    output logic                     sub_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] phase;
    always_ff @(posedge clk) begin
        phase <= rst ? 5'h00 : phase + 5'h01;
    end
    assign tick = '{phase == 5'h1F, phase[3:0] == 4'hF, phase[1:0] == 2'h3};
    // Sub-clock unrelated in phase to clk
    initial begin
        sub_clock = 1'b0;
        forever #163 sub_clock = ~sub_clock;
    end
endmodule : cmt_src_model
`default_nettype wire

/* File: verif/test_compare_match_timer_16_or_dual8.sv */
// Bench: reset values, strobe, dual 8-bit match, 16-bit wrap.
// Assumes the source model drives ticks and the sub-clock.
`default_nettype none
module test_compare_match_timer_16_or_dual8;
    timeunit 1ns;
    timeprecision 1ns;
    import cmt_pkg::*;
    logic          CLK = 1'b0, RST = 1'b1, SUB_ACTIVE = 1'b0, SUB_CLOCK;
    logic          AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [7:0]    AWADDR = 8'h00, ARADDR = 8'h00, v, c;
    logic [31:0]   WDATA = 32'h0000_0000, RDATA;
    logic [3:0]    WSTRB = 4'hF;
    logic [1:0]    BRESP, RRESP, r;
    logic          AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic          HIGH_TOGGLE_PIN, LOW_TOGGLE_PIN, HIGH_IRQ, LOW_IRQ;
    cmt_ticks_type PRESCALE_TICK;
    int            errors = 0, total_checks = 0, seed = 32'h7f3e, n;
    cmt_src_model SRC (.clk(CLK), .rst(RST), .tick(PRESCALE_TICK), .sub_clock(SUB_CLOCK));
    cmt_top DUT (.*);
    initial forever #25 CLK = ~CLK;
    task automatic results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic ck(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED at %0t got %h want %h", $time, s, e);
        end
    endtask : ck
    // Write: both channels offered, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        AWADDR <= a;
        WDATA <= {24'h00_0000, d};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 50 && BVALID !== 1'b1; n++) begin
            @(posedge CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
        end
        // A lost response ends the run
        if (BVALID !== 1'b1) begin
            errors++;
            results();
        end
        // Every bench write targets a mapped register
        ck({6'h00, BRESP}, {6'h00, RESP_OKAY});
        BREADY <= 1'b0;
        @(posedge CLK);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] q);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 50 && RVALID !== 1'b1; n++) begin
            @(posedge CLK);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
        end
        if (RVALID !== 1'b1) begin
            errors++;
            results();
        end
        d = RDATA[7:0];
        q = RRESP;
        RREADY <= 1'b0;
        @(posedge CLK);
    endtask : rd
    // Bounded wait for an interrupt pulse; a timeout ends the run
    task automatic wirq(input logic hi);
        for (n = 0; n < 600 && (hi ? HIGH_IRQ : LOW_IRQ) !== 1'b1; n++) @(posedge CLK);
        if (n >= 600) begin
            errors++;
            results();
        end
    endtask : wirq
    initial begin
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        WSTRB <= 4'hE;
        wr(OFS_CTRL, 8'h4A);
        WSTRB <= 4'hF;
        rd(OFS_CTRL, v, r); ck(v, CTRL_RESET);
        rd(OFS_CMP_LOW, v, r); ck(v, CMP_RESET);
        rd(8'h20, v, r); ck({6'h00, r}, {6'h00, RESP_DECERR});
        // Dual 8-bit, low half on /4 against a random compare byte
        c = 8'h10 + 8'($random(seed) & 7);
        wr(OFS_IRQ_EN, 8'h01);
        wr(OFS_STATUS, 8'h01);
        wr(OFS_CMP_LOW, c);
        wr(OFS_CNT_LOW, 8'h00);
        wr(OFS_CTRL, 8'h4A);
        ck({7'h00, LOW_TOGGLE_PIN}, 8'h01);
        wirq(1'b0);
        ck({7'h00, LOW_TOGGLE_PIN}, 8'h00);
        // High compare byte came from the empty holding byte, so the high half
        // also matched its zero count on its first /32 tick
        // status read before any flag clear
        rd(OFS_STATUS, v, r); ck(v, 8'h45);
        wr(OFS_STATUS, 8'h05);
        rd(OFS_STATUS, v, r); ck(v, 8'h05);
        wr(OFS_STATUS, 8'h01);
        rd(OFS_STATUS, v, r); ck(v, 8'h01);
        // 16-bit wrap: match and overflow leaving all ones
        // low pin carries no meaning here, left unchecked
        wr(OFS_IRQ_EN, 8'h02);
        wr(OFS_CTRL, 8'h02);
        wr(OFS_STATUS, 8'h20);
        wr(OFS_CMP_HIGH, 8'hFF);
        wr(OFS_CMP_LOW, 8'hFF);
        wr(OFS_CNT_HIGH, 8'hFF);
        wr(OFS_CNT_LOW, 8'hF0);
        wirq(1'b1);
        ck({7'h00, HIGH_TOGGLE_PIN}, 8'h01);
        rd(OFS_STATUS, v, r); ck(v, 8'hEC);
        rd(OFS_CNT_HIGH, v, r); ck(v, 8'h00);
        // Low-power state: prescaler sources stand still, sub-clock counts
        SUB_ACTIVE <= 1'b1;
        wr(OFS_CTRL, 8'h42);
        wr(OFS_CNT_LOW, 8'h33);
        repeat (40) @(posedge CLK);
        rd(OFS_CNT_LOW, v, r); ck(v, 8'h33);
        wr(OFS_CTRL, 8'h43);
        wr(OFS_CNT_LOW, 8'h90);
        rd(OFS_CNT_LOW, v, r); ck(v & 8'hF0, 8'h90);
        // Full speed on the sub-clock source: the write must be lost
        SUB_ACTIVE <= 1'b0;
        wr(OFS_CNT_LOW, 8'h10);
        rd(OFS_CNT_LOW, v, r); ck(v & 8'hF0, 8'h90);
        results();
    end
endmodule : test_compare_match_timer_16_or_dual8
`default_nettype wire
